// [core/omic_pkg.sv]
// Shared constants for the oscillator mode and internal clock block.
// Assumes a single 40 MHz clock and a byte-addressed AXI4-Lite register map.
package omic_pkg;

  // Clock rates and derived cycle counts
  localparam int CLK_PERIOD_NS  = 25;
  localparam int CLK_HZ         = 40_000_000;
  localparam int FAST_HZ        = 8_000_000;
  localparam int SLOW_PERIOD_NS = 32_000;
  localparam int FAST_CYCLES    = CLK_HZ / FAST_HZ;
  localparam int SLOW_CYCLES    = SLOW_PERIOD_NS / CLK_PERIOD_NS;

  // Tuning: one step is 1/256, so 32 steps span 12.5 percent
  localparam int          TUNE_SCALE  = 256;
  localparam logic [8:0]  TUNE_BASE   = 9'h100;
  localparam logic [19:0] FAST_THRESH = 20'(FAST_CYCLES * TUNE_SCALE);
  localparam logic [19:0] SLOW_THRESH = 20'(SLOW_CYCLES * TUNE_SCALE);

  // Register map, byte addresses
  localparam int         ADDR_W   = 8;
  localparam logic [7:0] REG_TUNE = 8'h90;
  localparam logic [7:0] REG_FSEL = 8'h94;
  localparam logic [7:0] REG_STAT = 8'h98;

  // Field positions and reset values
  localparam int         FSEL_LSB     = 4;
  localparam int         STAT_SLOW_ON = 4;
  localparam int         STAT_FAST_ON = 5;
  localparam logic [5:0] TUNE_RST     = 6'h00;
  localparam logic [2:0] FSEL_RST     = 3'h0;

  // Frequency select codes at the two ends of the range
  localparam logic [2:0] FSEL_FAST = 3'h7;
  localparam logic [2:0] FSEL_SLOW = 3'h0;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Oscillator mode configuration codes
  typedef enum logic [2:0] {
    MODE_LP     = 3'h0,
    MODE_XT     = 3'h1,
    MODE_HS     = 3'h2,
    MODE_RC     = 3'h3,
    MODE_RESISTOR_CAPACITOR_IO_MODE   = 3'h4,
    MODE_INTERNAL_OSC_CLKOUT_MODE = 3'h5,
    MODE_INTERNAL_OSC_DUAL_IO_MODE = 3'h6,
    MODE_EXTERNAL_CLOCK_IO_MODE   = 3'h7
  } omic_mode_t;

endpackage

// [core/omic_nco.sv]
// Tunable tick source: emits one-cycle pulses at a tuned fraction of clk.
// Assumes tune is a two's complement step count from the register file.
`timescale 1ns/10ps
module omic_nco import omic_pkg::*; #(
  parameter logic [19:0] THRESH = FAST_THRESH
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Control
  input  wire logic       en,
  input  wire logic [5:0] tune,
  // Output
  output logic            tick
);

  logic [19:0] acc_reg;
  logic [19:0] acc_sum;
  logic [8:0]  inc;

  // Constant step per code, centre at zero
  assign inc     = TUNE_BASE + {{3{tune[5]}}, tune};
  assign acc_sum = acc_reg + {11'h000, inc};

  // Phase accumulator, new step used from the next cycle on
  always_ff @(posedge clk) begin
    if (!nrst || !en) begin
      acc_reg <= 20'h00000;
      tick    <= 1'b0;
    end else if (acc_sum >= THRESH) begin
      acc_reg <= acc_sum - THRESH;
      tick    <= 1'b1;
    end else begin
      acc_reg <= acc_sum;
      tick    <= 1'b0;
    end
  end

  a_step_linear: assert property (@(posedge clk) disable iff (!nrst)
    acc_reg != $past(acc_reg) && en && $past(en) && !tick
      |-> acc_reg - $past(acc_reg) == {11'h000, $past(inc)})
    else $error("accumulator step does not follow tuning code");

endmodule

// [core/omic_axil.sv]
// AXI4-Lite slave front end: one write and one read in flight at a time.
// Assumes the register file decodes addresses and answers combinationally.
`timescale 1ns/10ps
module omic_axil import omic_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // Write address and data
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  // Write response
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // Read channels
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Register file side
  output logic                   wr_en,
  output logic [ADDR_W-1:0]      wr_addr,
  output logic [31:0]            wr_data,
  output logic [3:0]             wr_strb,
  input  wire logic              wr_ok,
  output logic [ADDR_W-1:0]      rd_addr,
  input  wire logic [31:0]       rd_data,
  input  wire logic              rd_ok
);

  logic aw_got_reg;
  logic w_got_reg;

  // Each channel is taken on its own, the write fires once both are held
  assign awready = !aw_got_reg && !bvalid;
  assign wready  = !w_got_reg && !bvalid;
  assign wr_en   = aw_got_reg && w_got_reg && !bvalid;
  assign arready = !rvalid;
  assign rd_addr = araddr;

  // Write address holding
  always_ff @(posedge clk) begin
    if (!nrst) begin
      aw_got_reg <= 1'b0;
      wr_addr    <= '0;
    end else if (awvalid && awready) begin
      aw_got_reg <= 1'b1;
      wr_addr    <= awaddr;
    end else if (wr_en) begin
      aw_got_reg <= 1'b0;
    end
  end

  // Write data holding
  always_ff @(posedge clk) begin
    if (!nrst) begin
      w_got_reg <= 1'b0;
      wr_data   <= 32'h00000000;
      wr_strb   <= 4'h0;
    end else if (wvalid && wready) begin
      w_got_reg <= 1'b1;
      wr_data   <= wdata;
      wr_strb   <= wstrb;
    end else if (wr_en) begin
      w_got_reg <= 1'b0;
    end
  end

  // Write response, error for unmapped addresses
  always_ff @(posedge clk) begin
    if (!nrst) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_ok ? rd_data : 32'h00000000;
      rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule

// [core/omic_top.sv]
// Top level: oscillator mode pin muxing, internal sources, register file.
// Assumes pins arrive asynchronously and port bit logic shares clk.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/10ps
module omic_top import omic_pkg::*; (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              nrst,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Configuration and enables
  input  wire logic [2:0]        oscillator_mode_config,
  input  wire logic              power_up_timer_enable,
  input  wire logic              watchdog_timer_enable,
  // Oscillator pins
  input  wire logic              oscillator_pin_one_in,
  output logic                   oscillator_pin_one_out,
  output logic                   oscillator_pin_one_oe_n,
  input  wire logic              oscillator_pin_two_in,
  output logic                   oscillator_pin_two_out,
  output logic                   oscillator_pin_two_oe_n,
  // Port bits shared with the pins
  input  wire logic              port_a_bit_six_out,
  input  wire logic              port_a_bit_six_tris,
  output logic                   port_a_bit_six_in,
  input  wire logic              port_a_bit_seven_out,
  input  wire logic              port_a_bit_seven_tris,
  output logic                   port_a_bit_seven_in,
  // Clock enables and source status
  output logic                   sys_clk_en,
  output logic                   slow_clk_en,
  output logic                   slow_source_on,
  output logic                   fast_source_on
);

  omic_mode_t        mode_reg;
  logic [5:0]        tune_reg;
  logic [2:0]        fsel_reg;
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic [3:0]        wr_strb;
  logic              wr_ok;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0]       rd_data;
  logic              rd_ok;
  logic [2:0]        p1_sync_reg;
  logic [2:0]        p2_sync_reg;
  logic              p1_filt_reg;
  logic              p1_prev_reg;
  logic              p2_filt_reg;
  logic              ext_edge;
  logic              internal_mode;
  logic              ext_mode;
  logic              fast_tick;
  logic              slow_tick;
  logic [5:0]        post_cnt_reg;
  logic [5:0]        post_tap;
  logic              sys_next;
  logic [1:0]        div_cnt_reg;
  logic              slow_on_next;

  // Bus slave
  omic_axil u_axil (
    .clk     (clk),
    .nrst    (nrst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_en   (wr_en),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  // Mode strap is caught while reset is held and then frozen
  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_reg <= omic_mode_t'(oscillator_mode_config);
    end
  end

  assign internal_mode = (mode_reg == MODE_INTERNAL_OSC_CLKOUT_MODE) || (mode_reg == MODE_INTERNAL_OSC_DUAL_IO_MODE);
  assign ext_mode      = !internal_mode;

  // Register writes, only the low byte lane carries data
  always_ff @(posedge clk) begin
    if (!nrst) begin
      tune_reg <= TUNE_RST;
      fsel_reg <= FSEL_RST;
    end else if (wr_en && wr_strb[0]) begin
      if (wr_addr == REG_TUNE) begin
        tune_reg <= wr_data[5:0];
      end
      if (wr_addr == REG_FSEL) begin
        fsel_reg <= wr_data[FSEL_LSB+2:FSEL_LSB];
      end
    end
  end

  assign wr_ok = (wr_addr == REG_TUNE) || (wr_addr == REG_FSEL) || (wr_addr == REG_STAT);

  // Register reads; status has no tuning-done flag
  always_comb begin
    rd_data = 32'h00000000;
    rd_ok   = 1'b1;
    case (rd_addr)
      REG_TUNE: rd_data[5:0] = tune_reg;
      REG_FSEL: rd_data[FSEL_LSB+2:FSEL_LSB] = fsel_reg;
      REG_STAT: begin
        rd_data[2:0]          = mode_reg;
        rd_data[STAT_SLOW_ON] = slow_source_on;
        rd_data[STAT_FAST_ON] = fast_source_on;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Pin synchronisers; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      p1_sync_reg <= 3'h0;
      p2_sync_reg <= 3'h0;
      p1_filt_reg <= 1'b0;
      p2_filt_reg <= 1'b0;
      p1_prev_reg <= 1'b0;
    end else begin
      p1_sync_reg <= {p1_sync_reg[1:0], oscillator_pin_one_in};
      p2_sync_reg <= {p2_sync_reg[1:0], oscillator_pin_two_in};
      p1_prev_reg <= p1_filt_reg;
      if (p1_sync_reg[1] == p1_sync_reg[2]) begin
        p1_filt_reg <= p1_sync_reg[2];
      end
      if (p2_sync_reg[1] == p2_sync_reg[2]) begin
        p2_filt_reg <= p2_sync_reg[2];
      end
    end
  end

  // External clock edges count straight away, no start-up wait
  assign ext_edge = ext_mode && p1_filt_reg && !p1_prev_reg;

  // Source enables
  assign slow_on_next = (internal_mode && fsel_reg == FSEL_SLOW)
                        || power_up_timer_enable || watchdog_timer_enable;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      slow_source_on <= 1'b0;
      fast_source_on <= 1'b0;
    end else begin
      slow_source_on <= slow_on_next;
      fast_source_on <= internal_mode && fsel_reg != FSEL_SLOW;
    end
  end

  // Tuned internal sources
  omic_nco #(.THRESH(FAST_THRESH)) u_fast (
    .clk  (clk),
    .nrst (nrst),
    .en   (fast_source_on),
    .tune (tune_reg),
    .tick (fast_tick)
  );

  omic_nco #(.THRESH(SLOW_THRESH)) u_slow (
    .clk  (clk),
    .nrst (nrst),
    .en   (slow_source_on),
    .tune (tune_reg),
    .tick (slow_tick)
  );

  assign slow_clk_en = slow_tick;

  // Postscaler counter on fast ticks
  always_ff @(posedge clk) begin
    if (!nrst) begin
      post_cnt_reg <= 6'h00;
    end else if (fast_tick) begin
      post_cnt_reg <= post_cnt_reg + 6'h01;
    end
  end

  // Tap i divides the fast source by 2 to the power i+1
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_tap
      assign post_tap[gi] = fast_tick && (&post_cnt_reg[gi:0]);
    end
  endgenerate

  // System tick source selection
  always_comb begin
    if (ext_mode) begin
      sys_next = ext_edge;
    end else begin
      case (fsel_reg)
        FSEL_FAST: sys_next = fast_tick;
        FSEL_SLOW: sys_next = slow_tick;
        default:   sys_next = post_tap[3'(3'h6 - fsel_reg)];
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sys_clk_en <= 1'b0;
    end else begin
      sys_clk_en <= sys_next;
    end
  end

  // Divide-by-four counter for the clock output
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_cnt_reg <= 2'h0;
    end else if (sys_clk_en) begin
      div_cnt_reg <= div_cnt_reg + 2'h1;
    end
  end

  // Pin two: clock output, port bit six, or left to the oscillator
  always_ff @(posedge clk) begin
    if (!nrst) begin
      oscillator_pin_two_out  <= 1'b0;
      oscillator_pin_two_oe_n <= 1'b1;
    end else begin
      unique case (mode_reg)
        MODE_RC, MODE_INTERNAL_OSC_CLKOUT_MODE: begin
          oscillator_pin_two_out  <= div_cnt_reg[1];
          oscillator_pin_two_oe_n <= 1'b0;
        end
        MODE_RESISTOR_CAPACITOR_IO_MODE, MODE_EXTERNAL_CLOCK_IO_MODE, MODE_INTERNAL_OSC_DUAL_IO_MODE: begin
          oscillator_pin_two_out  <= port_a_bit_six_out;
          oscillator_pin_two_oe_n <= port_a_bit_six_tris;
        end
        default: begin
          oscillator_pin_two_out  <= 1'b0;
          oscillator_pin_two_oe_n <= 1'b1;
        end
      endcase
    end
  end

  // Pin one: port bit seven in internal modes, clock input otherwise
  always_ff @(posedge clk) begin
    if (!nrst) begin
      oscillator_pin_one_out  <= 1'b0;
      oscillator_pin_one_oe_n <= 1'b1;
    end else if (internal_mode) begin
      oscillator_pin_one_out  <= port_a_bit_seven_out;
      oscillator_pin_one_oe_n <= port_a_bit_seven_tris;
    end else begin
      oscillator_pin_one_out  <= 1'b0;
      oscillator_pin_one_oe_n <= 1'b1;
    end
  end

  // Port bit reads, zero where the pin belongs to the oscillator
  assign port_a_bit_six_in = (mode_reg == MODE_RESISTOR_CAPACITOR_IO_MODE || mode_reg == MODE_EXTERNAL_CLOCK_IO_MODE
                              || mode_reg == MODE_INTERNAL_OSC_DUAL_IO_MODE) && p2_filt_reg;
  assign port_a_bit_seven_in = internal_mode && p1_filt_reg;

  // Helper: cycles between slow ticks while tuning stays at centre
  logic [15:0] gap_cnt_reg;
  logic        gap_ok_reg;
  always_ff @(posedge clk) begin
    if (!nrst || !slow_source_on || tune_reg != 6'h00) begin
      gap_cnt_reg <= 16'h0000;
      gap_ok_reg  <= 1'b0;
    end else if (slow_tick) begin
      gap_cnt_reg <= 16'h0000;
      gap_ok_reg  <= 1'b1;
    end else begin
      gap_cnt_reg <= gap_cnt_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_ext_no_wait: assert property (ext_edge |=> sys_clk_en)
    else $error("external clock edge not passed on at once");
  a_external_clock_io_mode_pin_two: assert property (mode_reg == MODE_EXTERNAL_CLOCK_IO_MODE ##1 1
      |-> oscillator_pin_two_oe_n == $past(port_a_bit_six_tris))
    else $error("pin two not port bit six in external clock mode");
  a_rc_clkout: assert property (mode_reg == MODE_RC && sys_clk_en
      && div_cnt_reg == 2'h1 |=> ##1 oscillator_pin_two_out && !oscillator_pin_two_oe_n)
    else $error("clock output not at quarter rate");
  a_resistor_capacitor_io_mode_pin_two: assert property (mode_reg == MODE_RESISTOR_CAPACITOR_IO_MODE
      |=> oscillator_pin_two_out == $past(port_a_bit_six_out))
    else $error("pin two not port bit six in RC I/O mode");
  a_fast_direct: assert property (internal_mode && fsel_reg == FSEL_FAST
      && fast_tick |=> sys_clk_en)
    else $error("fast source not driving system clock");
  a_slow_period: assert property (slow_tick && gap_ok_reg && tune_reg == 6'h00
      |-> gap_cnt_reg == 16'(SLOW_CYCLES - 1))
    else $error("slow source period wrong at centre tuning");
  a_slow_enable: assert property ((power_up_timer_enable || watchdog_timer_enable)
      |=> slow_source_on)
    else $error("slow source off while a timer needs it");
  a_post_slowest: assert property (internal_mode && fsel_reg == 3'h1 && sys_next
      |-> fast_tick && post_cnt_reg == 6'h3F)
    else $error("lowest postscaler tap not divide by 64");
  a_internal_osc_clkout_mode_pins: assert property (mode_reg == MODE_INTERNAL_OSC_CLKOUT_MODE
      |=> !oscillator_pin_two_oe_n
          && oscillator_pin_one_oe_n == $past(port_a_bit_seven_tris))
    else $error("internal clock-out mode pins wrong");
  a_internal_osc_dual_io_mode_pins: assert property (mode_reg == MODE_INTERNAL_OSC_DUAL_IO_MODE
      |=> oscillator_pin_one_out == $past(port_a_bit_seven_out)
          && oscillator_pin_two_out == $past(port_a_bit_six_out))
    else $error("internal dual I/O mode pins wrong");
  a_tune_read: assert property (arvalid && arready && araddr == REG_TUNE
      |=> rdata[31:6] == 26'h0 && rdata[5:0] == $past(tune_reg))
    else $error("tuning read back wrong");
  a_tune_applied: assert property (wr_en && wr_strb[0] && wr_addr == REG_TUNE
      |=> tune_reg == $past(wr_data[5:0]))
    else $error("tuning write not applied next cycle");
  a_mode_frozen: assert property ($stable(mode_reg))
    else $error("mode changed outside reset");
  a_tune_reset: assert property (@(posedge clk) $rose(nrst) |-> tune_reg == TUNE_RST)
    else $error("tuning not at centre after reset");

  c_ext_tick: cover property (mode_reg == MODE_EXTERNAL_CLOCK_IO_MODE && sys_clk_en);
  c_post_tick: cover property (internal_mode && fsel_reg == 3'h4 && sys_clk_en);
  c_slow_tick: cover property (internal_mode && fsel_reg == FSEL_SLOW && sys_clk_en);
  c_tune_write: cover property (wr_en && wr_addr == REG_TUNE && wr_data[5]);

endmodule

// [tb/omic_ext_clk.sv]
// External clock source or RC network model driving oscillator pin one.
// Assumes the bench clock paces it; the pin holds a level while stopped.
`timescale 1ns/10ps
module omic_ext_clk #(
  parameter int HALF = 4
) (
  // Clock
  input  wire logic clk,
  // Control
  input  wire logic run,
  input  wire logic lvl,
  // Pin
  output logic      pin
);
  int cnt;

  // Toggle every HALF cycles while running, else hold the requested level
  always_ff @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
      pin <= lvl;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      pin <= ~pin;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [tb/test_omic_top.sv]
// Self-checking bench for the oscillator mode and internal clock block.
// Assumes a 40 MHz clock, AXI4-Lite master tasks and the pin-one clock model.
`timescale 1ns/10ps
module test_omic_top;
  import omic_pkg::*;
  logic clk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic [2:0] cfg = 3'h7;
  logic awready, wready, bvalid, arready, rvalid, pu = 0, wdt = 0, run = 0, lvl = 0, p1;
  logic p1_out, p1_oe_n, p2_in = 0, p2_out, p2_oe_n, six_out = 0, six_tris = 1, six_in;
  logic sev_out = 0, sev_tris = 1, sev_in, sys, slow, slow_on, fast_on;
  int fail_count = 0, n_compared = 0;

  // Clock at 40 MHz
  always #12.5 clk = ~clk;

  omic_ext_clk #(.HALF(4)) i_src (.clk(clk), .run(run), .lvl(lvl), .pin(p1));

  omic_top i_dut (.clk(clk), .nrst(nrst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .oscillator_mode_config(cfg), .power_up_timer_enable(pu), .watchdog_timer_enable(wdt),
    .oscillator_pin_one_in(p1), .oscillator_pin_one_out(p1_out),
    .oscillator_pin_one_oe_n(p1_oe_n), .oscillator_pin_two_in(p2_in),
    .oscillator_pin_two_out(p2_out), .oscillator_pin_two_oe_n(p2_oe_n),
    .port_a_bit_six_out(six_out), .port_a_bit_six_tris(six_tris), .port_a_bit_six_in(six_in),
    .port_a_bit_seven_out(sev_out), .port_a_bit_seven_tris(sev_tris),
    .port_a_bit_seven_in(sev_in), .sys_clk_en(sys), .slow_clk_en(slow),
    .slow_source_on(slow_on), .fast_source_on(fast_on));

  // Count and report one comparison
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask

  // Print the counts and the verdict, then stop
  task automatic test_done();
    $display("compared %0d, mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Reset with a mode strap applied while reset is low
  task automatic rst(input logic [2:0] m);
    nrst <= 1'b0;
    cfg <= m;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask

  // AXI4-Lite write; each channel released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
  endtask

  // AXI4-Lite read; data and response taken at the rvalid edge
  task automatic rdr(input logic [7:0] a, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rready <= 1'b0;
    chk(32'(rresp), 32'(er));
  endtask

  // Cycles between two pulses of the system or slow tick
  task automatic per(input bit s, input int e);
    int n;
    do @(posedge clk); while (!(s ? slow : sys));
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!(s ? slow : sys));
    chk(32'(n), 32'(e));
  endtask

  // Cycles between two system ticks, within a band
  task automatic per_rng(input int lo, input int hi_lim);
    int n;
    do @(posedge clk); while (!sys);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (!sys);
    n_compared++;
    if (n < lo || n > hi_lim) begin
      fail_count++;
      $display("[ERR] %0t period %0d outside %0d..%0d", $time, n, lo, hi_lim);
    end
  endtask

  // High time of the clock output on pin two
  task automatic hi(input int e);
    int n;
    do @(posedge clk); while (p2_out);
    do @(posedge clk); while (!p2_out);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (p2_out);
    chk(32'(n), 32'(e));
  endtask

  // Tuning register reset, width, unmapped place and read-only status
  task automatic t_regs();
    rst(MODE_EXTERNAL_CLOCK_IO_MODE);
    rdr(REG_TUNE, RESP_OKAY);
    chk(rd, 32'h0);
    wr(REG_TUNE, 32'hFF, RESP_OKAY);
    rdr(REG_TUNE, RESP_OKAY);
    chk(rd, 32'h3F);
    wr(8'h80, 32'h1, RESP_SLVERR);
    rdr(8'h80, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(REG_STAT, 32'h0, RESP_OKAY);
    rdr(REG_STAT, RESP_OKAY);
    chk(32'(rd[2:0]), 32'h7);
    wr(REG_TUNE, 32'h00, RESP_OKAY);
  endtask

  // External clock: ticks at once, pin two is port bit six, slow source enables
  task automatic t_external_clock_io_mode();
    run <= 1'b1;
    rst(MODE_EXTERNAL_CLOCK_IO_MODE);
    per(0, 8);
    six_tris <= 1'b0;
    six_out <= 1'b1;
    p2_in <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'({p2_oe_n, p2_out, six_in}), 32'h3);
    chk(32'(slow_on), 32'h0);
    wdt <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(slow_on), 32'h1);
    wdt <= 1'b0;
    pu <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(slow_on), 32'h1);
    pu <= 1'b0;
  endtask

  // RC with clock out, then RC with pin two as port bit six
  task automatic t_rc();
    rst(MODE_RC);
    hi(16);
    chk(32'(p2_oe_n), 32'h0);
    rst(MODE_RESISTOR_CAPACITOR_IO_MODE);
    six_out <= 1'b0;
    repeat (8) @(posedge clk);
    chk(32'({p2_oe_n, p2_out, six_in}), 32'h1);
    rst(MODE_HS);
    repeat (8) @(posedge clk);
    chk(32'({p1_oe_n, p2_oe_n, six_in}), 32'h6);
  endtask

  // Internal modes: pin use, every select code, slow source
  task automatic t_int();
    run <= 1'b0;
    lvl <= 1'b1;
    rst(MODE_INTERNAL_OSC_CLKOUT_MODE);
    wr(REG_FSEL, 32'h70, RESP_OKAY);
    hi(10);
    chk(32'(sev_in), 32'h1);
    for (int k = 7; k >= 1; k--) begin
      wr(REG_FSEL, 32'(k) << FSEL_LSB, RESP_OKAY);
      per(0, 5 << (7 - k));
    end
    wr(REG_TUNE, 32'h1F, RESP_OKAY);
    per_rng(285, 286);
    wr(REG_TUNE, 32'h20, RESP_OKAY);
    per_rng(365, 366);
    wr(REG_TUNE, 32'h00, RESP_OKAY);
    wr(REG_FSEL, 32'h00, RESP_OKAY);
    per(0, 1280);
    per(1, 1280);
    chk(32'({slow_on, fast_on}), 32'h2);
    rst(MODE_INTERNAL_OSC_DUAL_IO_MODE);
    sev_tris <= 1'b0;
    sev_out <= 1'b1;
    six_out <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'({p1_oe_n, p2_oe_n, p2_out, p1_out}), 32'h3);
  endtask

  // Main sequence
  initial begin
    t_regs();
    t_external_clock_io_mode();
    t_rc();
    t_int();
    test_done();
  end

  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule
